// file: src/tpf_regs.svh
// register offsets, field positions, reset values and pin counts of the pin-function block
`ifndef TPF_REGS_SVH
`define TPF_REGS_SVH

// ************************
// register addresses and port-control word numbers
// ************************
`define TPF_READBACK_ADDR 4'he
`define TPF_PW_ADC_SEL 4'h1
`define TPF_PW_COUNTER 4'h3
`define TPF_PW_ANALOG_LO 4'h7
`define TPF_PW_ANALOG_HI 4'h8

// ************************
// field positions
// ************************
`define TPF_PW3_HIGH_FREQ_COUNT_PIN_BIT 3
`define TPF_PW3_LOW_FREQ_COUNT_PIN_BIT 2
`define TPF_PW3_EDGE_B_BIT 1
`define TPF_PW3_EDGE_A_BIT 0
`define TPF_BEEP_EN_BIT 3
`define TPF_START_ADC_BIT 2
`define TPF_CW_AM_SEL_BIT 3

// ************************
// reset values and sizes
// ************************
`define TPF_PW3_RESET 4'h0
`define TPF_ANALOG_PINS 6
`define TPF_PUSH_PULL_BITS 16
`define TPF_OD_BITS 4

`endif

// file: src/tpf_pkg.sv
// types shared by the pin-function block
package tpf_pkg;

	// universal counter modes, from the mode instruction bits 3:2
	typedef enum logic [1:0] {
		TPF_CNT_HIGH_FREQ = 2'b00,
		TPF_CNT_LOW_FREQ = 2'b01,
		TPF_CNT_LOW_PERIOD = 2'b10,
		TPF_CNT_RESERVED = 2'b11
	} tpf_cnt_mode_t;

	// low-power state, one-hot
	typedef enum logic [1:0] {
		TPF_RUN = 2'b01,
		TPF_HALTED = 2'b10
	} tpf_power_t;

endpackage : tpf_pkg

// file: src/tpf_pump_drive.sv
// tristate drive for one charge pump output from phase comparator results
module tpf_pump_drive
#(
	parameter bit INVERT = 1'b0
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic osc_above,
	input wire logic osc_below,
	input wire logic force_off,
	output logic pump_out,
	output logic pump_oe
);

	// ************************
	// registered drive
	// ************************

	// above drives high (low if inverted), below the opposite, match floats
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pump_out <= 1'b0;
			pump_oe <= 1'b0;
		end
		else if (force_off || (osc_above == osc_below))
		begin
			pump_out <= 1'b0;
			pump_oe <= 1'b0;
		end
		else
		begin
			pump_out <= osc_above ^ INVERT;
			pump_oe <= 1'b1;
		end
	end

endmodule : tpf_pump_drive

// file: src/tpf_pin_control.sv
// pin-function and mode control of the tuning controller's shared pins
// ************************
// Summary of operation
// [R1] fm oscillator pin routed when pll word selects fm; low two bits ignored
// [R2] am oscillator pin routed when selected; low two bits give am band
// [R3] both oscillator inputs off in suspend, halt, reset and pll stop
// [R4] dead-zone op drives aux pump; floats under suspend, halt, reset, pll stop
// [R5] second pump low when above, high when below, floats on match or off
// [R6] word 3 bit 3 picks counter or general input for high pin
// [R7] word 3 bit 2 picks counter or general input for low pin
// [R8] counter mode bits 3:2 select measurement; start op begins the count
// [R9] count-done flag set when the measurement interval ends
// [R10] general-input levels read at 0x0e: high pin bit 0, low pin bit 1
// [R11] counter pins input disabled and pulled down while halted
// [R12] reset selects counter function, high-pin frequency mode
// [R13] suspend blocks inputs and floats pumps; halt needs flag, pin low, op
// [R14] halt ends when the suspend pin returns high
// [R15] words 7 and 8 choose general or analog per analog pin
// [R16] word 1 picks conversion pin; start bit 2 launches; done flag set
// [R17] digital read of an analog-mode pin returns low
// [R18] open-drain port off in halt and after reset
// [R19] interrupt pin active only with its enable, input mode, global enable
// [R20] word 3 bits 1 and 0 choose edge for interrupts b and a
// [R21] tone bit 3 selects tone or port; bits 2:0 frequency; latch kept
// [R22] push-pull outputs float in halt and until first write after reset
// [R23] main pumps high when above, low when below
// ************************
`include "tpf_regs.svh"
module tpf_pin_control
import tpf_pkg::*;
#(
	parameter int ANALOG_PINS = `TPF_ANALOG_PINS,
	parameter int PP_BITS = `TPF_PUSH_PULL_BITS
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic pll_stop,
	input wire logic suspend_n_pin,
	input wire logic suspend_enable_flag,
	input wire logic clock_halt_op,
	input wire logic pll_cw_wr,
	input wire logic [3:0] pll_control_word_one,
	input wire logic fm_osc_input,
	input wire logic am_osc_input,
	output logic fm_to_pll,
	output logic am_to_pll,
	output logic [1:0] am_band,
	input wire logic dead_zone_op,
	input wire logic [1:0] dead_zone_data,
	input wire logic osc_above,
	input wire logic osc_below,
	output logic aux_pump_output,
	output logic aux_pump_oe,
	output logic second_pump_output,
	output logic second_pump_oe,
	output logic main_pump_output_a,
	output logic main_pump_output_b,
	output logic main_pump_oe,
	input wire logic port_setup_op,
	input wire logic [3:0] port_control_word_number,
	input wire logic [3:0] port_setup_data,
	input wire logic counter_mode_op,
	input wire logic [3:0] counter_mode_data,
	input wire logic counter_start_op,
	input wire logic [3:0] counter_start_data,
	input wire logic count_interval_end,
	input wire logic count_done_clear,
	input wire logic conversion_end,
	input wire logic conversion_done_clear,
	input wire logic high_freq_count_pin,
	input wire logic low_freq_count_pin,
	output logic high_cnt_to_counter,
	output logic low_cnt_to_counter,
	output logic count_pins_pulldown,
	output logic [1:0] counter_mode,
	output logic count_start,
	output logic count_done_flag,
	output logic adc_start,
	output logic [3:0] adc_channel,
	output logic conversion_done_flag,
	input wire logic [ANALOG_PINS-1:0] analog_in_pin,
	output logic [ANALOG_PINS-1:0] analog_to_adc,
	output logic [ANALOG_PINS-1:0] analog_digital_in,
	input wire logic register_read_op,
	input wire logic [3:0] register_read_addr,
	output logic [3:0] register_read_data,
	input wire logic register_write_op,
	input wire logic [3:0] od_write_data,
	output logic [3:0] open_drain_out_pin,
	output logic [3:0] open_drain_oe,
	input wire logic pp_write_op,
	input wire logic [PP_BITS-1:0] pp_write_data,
	output logic [PP_BITS-1:0] pp_out,
	output logic pp_oe,
	input wire logic beep_op,
	input wire logic [3:0] beep_data,
	input wire logic tone_wave,
	output logic [2:0] tone_freq_sel,
	output logic tone_shared_out_pin,
	output logic tone_shared_oe,
	input wire logic ext_irq_a_pin,
	input wire logic ext_irq_b_pin,
	input wire logic ext_irq_a_is_input,
	input wire logic ext_irq_b_is_input,
	input wire logic ext_irq_a_enable,
	input wire logic ext_irq_b_enable,
	input wire logic global_irq_enable,
	output logic ext_irq_a_req,
	output logic ext_irq_b_req,
	output logic halted
);

	// ************************
	// pin synchronisers
	// ************************
	localparam int SYNC_W = 5 + ANALOG_PINS;
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic susp_n_s, high_freq_count_pin_s, low_freq_count_pin_s, irq_a_s, irq_b_s;
	logic [ANALOG_PINS-1:0] analog_s;

	// two flops per pin; suspend bit resets high so no false suspend
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_reg <= SYNC_W'(1);
			sync2_reg <= SYNC_W'(1);
		end
		else
		begin
			sync1_reg <= {analog_in_pin, ext_irq_b_pin, ext_irq_a_pin, low_freq_count_pin,
				high_freq_count_pin, suspend_n_pin};
			sync2_reg <= sync1_reg;
		end
	end
	assign susp_n_s = sync2_reg[0];
	assign high_freq_count_pin_s = sync2_reg[1];
	assign low_freq_count_pin_s = sync2_reg[2];
	assign irq_a_s = sync2_reg[3];
	assign irq_b_s = sync2_reg[4];
	assign analog_s = sync2_reg[SYNC_W-1:5];

	// ************************
	// suspend and halt
	// ************************
	tpf_power_t power_reg;
	logic suspended, off_cond, reset_done_reg;

	// halt entry needs flag, low pin and op; exit on pin high
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			power_reg <= TPF_RUN;
		else
		begin
			case (power_reg)
				TPF_RUN:
					if (suspend_enable_flag && !susp_n_s && clock_halt_op)
						power_reg <= TPF_HALTED; // [R13]
				TPF_HALTED:
					if (susp_n_s)
						power_reg <= TPF_RUN; // [R14]
				default:
					power_reg <= TPF_RUN;
			endcase
		end
	end

	// first clock after reset release still counts as power-on reset
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			reset_done_reg <= 1'b0;
		else
			reset_done_reg <= 1'b1;
	end

	assign halted = (power_reg == TPF_HALTED);
	assign suspended = suspend_enable_flag && !susp_n_s; // [R13]
	assign off_cond = suspended || halted || !reset_done_reg || pll_stop; // [R3]

	// ************************
	// oscillator selection
	// ************************
	logic am_sel_reg;
	logic [1:0] am_band_reg;

	// pll word bit 3 picks am; fm ignores bits 1:0
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			am_sel_reg <= 1'b0;
			am_band_reg <= 2'b00;
		end
		else if (pll_cw_wr)
		begin
			am_sel_reg <= pll_control_word_one[`TPF_CW_AM_SEL_BIT];
			if (pll_control_word_one[`TPF_CW_AM_SEL_BIT])
				am_band_reg <= pll_control_word_one[1:0]; // [R2]
		end
	end

	assign fm_to_pll = !am_sel_reg && !off_cond && fm_osc_input; // [R1] [R3]
	assign am_to_pll = am_sel_reg && !off_cond && am_osc_input; // [R2] [R3]
	assign am_band = am_band_reg;

	// ************************
	// charge pumps
	// ************************
	logic [1:0] dz_reg;

	// dead-zone op sets aux pump drive: bit1 enable, bit0 level
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			dz_reg <= 2'b00;
		else if (dead_zone_op)
			dz_reg <= dead_zone_data; // [R4]
	end
	assign aux_pump_output = dz_reg[0];
	assign aux_pump_oe = dz_reg[1] && !off_cond; // [R4]

	// second pump has inverted polarity
	tpf_pump_drive #(.INVERT(1'b1)) u_second
	(
		.clk(clk),
		.arst_n(arst_n),
		.osc_above(osc_above),
		.osc_below(osc_below),
		.force_off(off_cond),
		.pump_out(second_pump_output),
		.pump_oe(second_pump_oe)
	); // [R5]

	// main pumps, straight polarity, both pins alike
	tpf_pump_drive #(.INVERT(1'b0)) u_main
	(
		.clk(clk),
		.arst_n(arst_n),
		.osc_above(osc_above),
		.osc_below(osc_below),
		.force_off(off_cond),
		.pump_out(main_pump_output_a),
		.pump_oe(main_pump_oe)
	); // [R23]
	assign main_pump_output_b = main_pump_output_a;

	// ************************
	// port-control words
	// ************************
	logic [3:0] pw3_reg;
	logic [3:0] adc_sel_reg;
	logic [7:0] analog_mode_reg;

	// setup op writes the addressed word
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pw3_reg <= `TPF_PW3_RESET; // [R12]
			adc_sel_reg <= 4'h0_000;
			analog_mode_reg <= 8'h0_000;
		end
		else if (port_setup_op)
		begin
			if (port_control_word_number == `TPF_PW_COUNTER)
				pw3_reg <= port_setup_data; // [R6] [R7] [R20]
			else if (port_control_word_number == `TPF_PW_ADC_SEL)
				adc_sel_reg <= port_setup_data; // [R16]
			else if (port_control_word_number == `TPF_PW_ANALOG_LO)
				analog_mode_reg[3:0] <= port_setup_data; // [R15]
			else if (port_control_word_number == `TPF_PW_ANALOG_HI)
				analog_mode_reg[7:4] <= port_setup_data; // [R15]
		end
	end
	assign adc_channel = adc_sel_reg;

	// ************************
	// universal counter pins and mode
	// ************************
	logic high_gp, low_gp, done_reg;
	logic [1:0] mode_reg;

	assign high_gp = pw3_reg[`TPF_PW3_HIGH_FREQ_COUNT_PIN_BIT];
	assign low_gp = pw3_reg[`TPF_PW3_LOW_FREQ_COUNT_PIN_BIT];
	assign high_cnt_to_counter = !high_gp && !halted && high_freq_count_pin; // [R6] [R11]
	assign low_cnt_to_counter = !low_gp && !halted && low_freq_count_pin; // [R7] [R11]
	assign count_pins_pulldown = halted; // [R11]

	// mode op loads bits 3:2
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			mode_reg <= TPF_CNT_HIGH_FREQ; // [R12]
		else if (counter_mode_op)
			mode_reg <= counter_mode_data[3:2]; // [R8]
	end
	assign counter_mode = mode_reg;
	assign count_start = counter_start_op && !counter_start_data[`TPF_START_ADC_BIT]; // [R8]
	assign adc_start = counter_start_op && counter_start_data[`TPF_START_ADC_BIT]; // [R16]

	// done flag: set wins over clear, cleared by a new start
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			done_reg <= 1'b0;
		else if (count_interval_end)
			done_reg <= 1'b1; // [R9]
		else if (count_done_clear || count_start)
			done_reg <= 1'b0;
	end
	assign count_done_flag = done_reg;

	// ************************
	// a/d pins
	// ************************
	logic adc_done_reg;

	// conversion-done flag, set wins over clear
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			adc_done_reg <= 1'b0;
		else if (conversion_end)
			adc_done_reg <= 1'b1; // [R16]
		else if (conversion_done_clear || adc_start)
			adc_done_reg <= 1'b0;
	end
	assign conversion_done_flag = adc_done_reg;

	// per pin: analog routes to adc, digital reads low
	genvar gi;
	generate
		for (gi = 0; gi < ANALOG_PINS; gi++)
		begin : g_analog
			assign analog_to_adc[gi] = analog_mode_reg[gi]; // [R15]
			assign analog_digital_in[gi] = !analog_mode_reg[gi] && !halted && analog_s[gi]; // [R17]
		end
	endgenerate

	// ************************
	// internal register read
	// ************************
	logic [3:0] rd_reg;

	// 0x0e shows general-input levels of the counter pins
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rd_reg <= 4'h0_000;
		else if (register_read_op)
		begin
			if (register_read_addr == `TPF_READBACK_ADDR)
				rd_reg <= {2'b00, low_gp && !halted && low_freq_count_pin_s, high_gp && !halted && high_freq_count_pin_s}; // [R10]
			else
				rd_reg <= 4'h0_000;
		end
	end
	assign register_read_data = rd_reg;

	// ************************
	// output ports
	// ************************
	logic [3:0] od_reg;
	logic [PP_BITS-1:0] pp_reg;
	logic pp_armed_reg;
	logic [3:0] beep_reg;

	// open-drain latch: 1 means transistor off
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			od_reg <= 4'h0_00f; // [R18]
		else if (register_write_op)
			od_reg <= od_write_data;
	end
	assign open_drain_out_pin = 4'h0_000;
	assign open_drain_oe = halted ? 4'h0_000 : ~od_reg; // [R18]

	// push-pull latch and first-write arming
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pp_reg <= '0;
			pp_armed_reg <= 1'b0;
		end
		else if (pp_write_op)
		begin
			pp_reg <= pp_write_data; // [R21]
			pp_armed_reg <= 1'b1; // [R22]
		end
	end
	assign pp_out = pp_reg;
	assign pp_oe = pp_armed_reg && !halted; // [R22]

	// tone control
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			beep_reg <= 4'h0_000;
		else if (beep_op)
			beep_reg <= beep_data;
	end
	assign tone_freq_sel = beep_reg[2:0];
	assign tone_shared_out_pin = beep_reg[`TPF_BEEP_EN_BIT] ? tone_wave : pp_reg[0]; // [R21]
	assign tone_shared_oe = (pp_armed_reg || beep_reg[`TPF_BEEP_EN_BIT]) && !halted; // [R22]

	// ************************
	// external interrupts
	// ************************
	logic irq_a_d_reg, irq_b_d_reg, edge_a, edge_b;

	// delayed copies for edge detection
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irq_a_d_reg <= 1'b0;
			irq_b_d_reg <= 1'b0;
		end
		else
		begin
			irq_a_d_reg <= irq_a_s;
			irq_b_d_reg <= irq_b_s;
		end
	end

	// bit set picks falling edge, clear picks rising
	assign edge_a = pw3_reg[`TPF_PW3_EDGE_A_BIT] ? (irq_a_d_reg && !irq_a_s)
		: (!irq_a_d_reg && irq_a_s); // [R20]
	assign edge_b = pw3_reg[`TPF_PW3_EDGE_B_BIT] ? (irq_b_d_reg && !irq_b_s)
		: (!irq_b_d_reg && irq_b_s); // [R20]
	assign ext_irq_a_req = edge_a && ext_irq_a_enable && ext_irq_a_is_input
		&& global_irq_enable && !halted; // [R19]
	assign ext_irq_b_req = edge_b && ext_irq_b_enable && ext_irq_b_is_input
		&& global_irq_enable && !halted; // [R19]

endmodule : tpf_pin_control

// file: verif/tpf_far_side.sv
// far-side model: local oscillators, phase comparator and suspend pin
module tpf_far_side
(
	input wire logic clk,
	input wire logic [1:0] phase_cmd,
	input wire logic suspend_req,
	output logic fm_osc_input,
	output logic am_osc_input,
	output logic osc_above,
	output logic osc_below,
	output logic suspend_n_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// oscillators run free, in opposite phase so a swapped route shows
	initial
	begin
		fm_osc_input = 1'b0;
		am_osc_input = 1'b1;
	end
	always @(posedge clk)
	begin
		fm_osc_input <= ~fm_osc_input;
		am_osc_input <= ~am_osc_input;
	end

	// comparator result: 1 above, 2 below, 0 match
	assign osc_above = (phase_cmd == 2'b01);
	assign osc_below = (phase_cmd == 2'b10);
	// pin pulled low to suspend, released high to wake
	assign suspend_n_pin = ~suspend_req;
endmodule : tpf_far_side

// file: verif/tpf_pin_monitor.sv
// concurrent checks on the ports of the pin-function block
module tpf_pin_monitor
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic pll_stop,
	input wire logic suspend_n_pin,
	input wire logic suspend_enable_flag,
	input wire logic clock_halt_op,
	input wire logic halted,
	input wire logic osc_above,
	input wire logic osc_below,
	input wire logic main_pump_output_a,
	input wire logic main_pump_output_b,
	input wire logic main_pump_oe,
	input wire logic second_pump_output,
	input wire logic second_pump_oe,
	input wire logic fm_to_pll,
	input wire logic am_to_pll,
	input wire logic aux_pump_oe,
	input wire logic count_pins_pulldown,
	input wire logic pp_oe,
	input wire logic [3:0] open_drain_oe,
	input wire logic high_cnt_to_counter,
	input wire logic low_cnt_to_counter,
	input wire logic counter_start_op,
	input wire logic [3:0] counter_start_data,
	input wire logic count_start,
	input wire logic adc_start,
	input wire logic count_interval_end,
	input wire logic count_done_flag,
	input wire logic [5:0] analog_to_adc,
	input wire logic [5:0] analog_digital_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// ************************
	// properties
	// ************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_pump_free;
		$past(arst_n) && !pll_stop && !suspend_enable_flag && !halted;
	endsequence
	sequence s_pin_back;
		halted && $rose(suspend_n_pin);
	endsequence

	property p_main_pol;
		s_pump_free ##0 (osc_above && !osc_below)
		|=> main_pump_oe && main_pump_output_a && main_pump_output_b;
	endproperty
	property p_second_pol;
		s_pump_free ##0 (osc_above ^ osc_below)
		|=> second_pump_oe && (second_pump_output == $past(osc_below));
	endproperty
	property p_match_float;
		!osc_above && !osc_below |=> !main_pump_oe && !second_pump_oe;
	endproperty
	property p_stop_inputs;
		pll_stop |-> !fm_to_pll && !am_to_pll && !aux_pump_oe;
	endproperty
	property p_halt_quiet;
		halted |-> count_pins_pulldown && !pp_oe && open_drain_oe == 4'h0
			&& !high_cnt_to_counter && !low_cnt_to_counter;
	endproperty
	property p_halt_refuse;
		clock_halt_op && !suspend_enable_flag && !halted |=> !halted;
	endproperty
	property p_wake;
		s_pin_back |-> ##[1:4] !halted;
	endproperty
	property p_start_split;
		counter_start_op |-> adc_start == counter_start_data[2]
			&& count_start == !counter_start_data[2];
	endproperty
	property p_count_done;
		count_interval_end |=> count_done_flag;
	endproperty
	property p_analog_block;
		(analog_to_adc & analog_digital_in) == 6'h00;
	endproperty

	a_main_pol: assert property (p_main_pol)
		else $error("main pump wrong");
	a_second_pol: assert property (p_second_pol)
		else $error("second pump wrong");
	a_match_float: assert property (p_match_float)
		else $error("pump driven on match");
	a_stop_inputs: assert property (p_stop_inputs)
		else $error("input live with pll stopped");
	a_halt_quiet: assert property (p_halt_quiet)
		else $error("pin active while halted");
	a_halt_refuse: assert property (p_halt_refuse)
		else $error("halt taken without enable");
	a_wake: assert property (p_wake)
		else $error("no wake from halt");
	a_start_split: assert property (p_start_split)
		else $error("wrong start pulse");
	a_count_done: assert property (p_count_done)
		else $error("count done flag missing");
	a_analog_block: assert property (p_analog_block)
		else $error("analog pin reads digital");
endmodule : tpf_pin_monitor

bind tpf_pin_control tpf_pin_monitor u_tpf_pin_monitor (.*);

// file: verif/test_tuner_mcu_pin_function_control.sv
// self-checking bench of the pin-function block
`include "tpf_regs.svh"
module test_tuner_mcu_pin_function_control;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, arst_n, pll_stop, suspend_n_pin, suspend_enable_flag, clock_halt_op, pll_cw_wr;
	logic fm_osc_input, am_osc_input, fm_to_pll, am_to_pll, dead_zone_op, osc_above, osc_below;
	logic aux_pump_output, aux_pump_oe, second_pump_output, second_pump_oe, main_pump_oe;
	logic main_pump_output_a, main_pump_output_b, port_setup_op, counter_mode_op;
	logic counter_start_op, count_interval_end, count_done_clear, conversion_end;
	logic conversion_done_clear, high_freq_count_pin, low_freq_count_pin, high_cnt_to_counter;
	logic low_cnt_to_counter, count_pins_pulldown, count_start, count_done_flag, adc_start;
	logic conversion_done_flag, register_read_op, register_write_op, pp_write_op, pp_oe;
	logic beep_op, tone_wave, tone_shared_out_pin, tone_shared_oe, ext_irq_a_pin, ext_irq_b_pin;
	logic ext_irq_a_is_input, ext_irq_b_is_input, ext_irq_a_enable, ext_irq_b_enable;
	logic global_irq_enable, ext_irq_a_req, ext_irq_b_req, halted, suspend_req;
	logic [1:0] dead_zone_data, am_band, counter_mode, phase_cmd, seen;
	logic [2:0] tone_freq_sel;
	logic [3:0] pll_control_word_one, port_control_word_number, port_setup_data;
	logic [3:0] counter_mode_data, counter_start_data, register_read_addr, od_write_data;
	logic [3:0] beep_data, adc_channel, register_read_data, open_drain_out_pin, open_drain_oe;
	logic [5:0] analog_in_pin, analog_to_adc, analog_digital_in;
	logic [15:0] pp_write_data, pp_out;
	int fail_count = 0;
	int cmp_count = 0;
	int n;
	// rows: word 3 data, pins {low, high}, expected readback
	logic [11:0] rows [5] = '{12'h831, 12'h432, 12'hc11, 12'hc22, 12'h030};

	tpf_pin_control #(.ANALOG_PINS(6), .PP_BITS(16)) u_tpf_pin_control (.*);
	tpf_far_side u_tpf_far_side (.*);

	// 50 MHz clock
	initial clk = 1'b0;
	always #10 clk = ~clk;

	// ************************
	// tasks
	// ************************
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task cyc(input int k);
		repeat (k) @(negedge clk);
	endtask : cyc

	// one-cycle instruction pulse with its data
	task op(input int k, input logic [15:0] d, input logic [3:0] w);
		@(negedge clk);
		case (k)
			0: {port_setup_op, port_control_word_number, port_setup_data} = {1'b1, w, d[3:0]};
			1: {counter_mode_op, counter_mode_data} = {1'b1, d[3:0]};
			2: {pll_cw_wr, pll_control_word_one} = {1'b1, d[3:0]};
			3: {dead_zone_op, dead_zone_data} = {1'b1, d[1:0]};
			4: {register_read_op, register_read_addr} = {1'b1, w};
			5: {register_write_op, od_write_data} = {1'b1, d[3:0]};
			6: {pp_write_op, pp_write_data} = {1'b1, d};
			7: {beep_op, beep_data} = {1'b1, d[3:0]};
			default: clock_halt_op = 1'b1;
		endcase
		@(negedge clk);
		{port_setup_op, counter_mode_op, pll_cw_wr, dead_zone_op, register_read_op} = '0;
		{register_write_op, pp_write_op, beep_op, clock_halt_op} = '0;
	endtask : op

	task test_done;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	// watchdog at 10000 cycles, far past the run
	initial
	begin
		#200us;
		fail_count++;
		$display("watchdog expired");
		test_done;
	end

	// ************************
	// main sequence
	// ************************
	initial
	begin
		{arst_n, pll_stop, suspend_enable_flag, clock_halt_op, pll_cw_wr, dead_zone_op} = '0;
		{port_setup_op, counter_mode_op, counter_start_op, count_interval_end} = '0;
		{count_done_clear, conversion_end, conversion_done_clear, high_freq_count_pin} = '0;
		{low_freq_count_pin, register_read_op, register_write_op, pp_write_op, beep_op} = '0;
		{tone_wave, ext_irq_a_pin, ext_irq_b_pin, ext_irq_a_is_input, ext_irq_b_is_input} = '0;
		{ext_irq_a_enable, ext_irq_b_enable, global_irq_enable, suspend_req, phase_cmd} = '0;
		{pll_control_word_one, dead_zone_data, port_control_word_number, port_setup_data} = '0;
		{counter_mode_data, counter_start_data, analog_in_pin, register_read_addr} = '0;
		{od_write_data, pp_write_data, beep_data} = '0;
		cyc(6);
		chk({fm_to_pll, am_to_pll, aux_pump_oe, main_pump_oe, second_pump_oe}, 16'h0000);
		chk(open_drain_oe, 16'h0000);
		chk({pp_oe, tone_shared_oe}, 16'h0000);
		chk({counter_mode, halted, count_done_flag}, 16'h0000);
		arst_n = 1'b1;
		cyc(2);
		$display("reset test done");
		foreach (rows[i])
		begin
			{low_freq_count_pin, high_freq_count_pin} = rows[i][5:4];
			op(0, rows[i][11:8], `TPF_PW_COUNTER);
			cyc(2);
			op(4, 16'h0000, `TPF_READBACK_ADDR);
			chk(register_read_data, rows[i][3:0]);
			chk({low_cnt_to_counter, high_cnt_to_counter}, rows[i][5:4] & ~{rows[i][10], rows[i][11]});
		end
		$display("table test done");
		op(2, 16'h000a, 4'h0);
		chk({fm_to_pll, am_to_pll}, {1'b0, am_osc_input});
		chk(am_band, 16'h0002);
		op(2, 16'h0003, 4'h0);
		chk({fm_to_pll, am_to_pll}, {fm_osc_input, 1'b0});
		op(3, 16'h0003, 4'h0);
		chk({aux_pump_oe, aux_pump_output}, 16'h0003);
		for (int p = 1; p < 3; p++)
		begin
			phase_cmd = p[1:0];
			cyc(2);
			chk({main_pump_oe, main_pump_output_a, main_pump_output_b}, {1'b1, p == 1, p == 1});
			chk({second_pump_oe, second_pump_output}, {1'b1, p == 2});
		end
		phase_cmd = 2'b00;
		cyc(2);
		chk({main_pump_oe, second_pump_oe}, 16'h0000);
		{phase_cmd, pll_stop} = 3'b011;
		cyc(2);
		chk({fm_to_pll, am_to_pll, aux_pump_oe, main_pump_oe, second_pump_oe}, 16'h0000);
		pll_stop = 1'b0;
		$display("pll test done");
		for (int m = 0; m < 3; m++)
		begin
			op(1, {m[1:0], 2'b00}, 4'h0);
			chk(counter_mode, m[1:0]);
		end
		op(0, 16'h0005, `TPF_PW_ADC_SEL);
		chk(adc_channel, 16'h0005);
		for (int s = 0; s < 2; s++)
		begin
			@(negedge clk) {counter_start_op, counter_start_data} = {1'b1, 1'b0, s[0], 2'b00};
			#1 chk({count_start, adc_start}, {~s[0], s[0]});
		end
		@(negedge clk) counter_start_op = 1'b0;
		{count_interval_end, conversion_end} = 2'b11;
		@(negedge clk) {count_interval_end, conversion_end} = 2'b00;
		chk({count_done_flag, conversion_done_flag}, 16'h0003);
		{count_done_clear, conversion_done_clear} = 2'b11;
		@(negedge clk) {count_done_clear, conversion_done_clear} = 2'b00;
		chk({count_done_flag, conversion_done_flag}, 16'h0000);
		$display("counter test done");
		analog_in_pin = 6'h3f;
		op(0, 16'h000f, `TPF_PW_ANALOG_LO);
		op(0, 16'h0003, `TPF_PW_ANALOG_HI);
		cyc(2);
		chk(analog_to_adc, 16'h003f);
		chk(analog_digital_in, 16'h0000);
		op(0, 16'h0000, `TPF_PW_ANALOG_LO);
		op(0, 16'h0000, `TPF_PW_ANALOG_HI);
		cyc(3);
		chk(analog_digital_in, 16'h003f);
		$display("analog test done");
		{ext_irq_a_is_input, ext_irq_b_is_input, ext_irq_a_enable, ext_irq_b_enable} = '1;
		for (int e = 0; e < 3; e++)
		begin
			global_irq_enable = (e > 0);
			op(0, (e == 2) ? 16'h0003 : 16'h0000, `TPF_PW_COUNTER);
			{ext_irq_a_pin, ext_irq_b_pin} = (e == 2) ? 2'b11 : 2'b00;
			cyc(4);
			seen = 2'b00;
			{ext_irq_a_pin, ext_irq_b_pin} = ~{ext_irq_a_pin, ext_irq_b_pin};
			repeat (6)
			begin
				@(negedge clk);
				seen = seen | {ext_irq_a_req, ext_irq_b_req};
			end
			chk(seen, (e > 0) ? 16'h0003 : 16'h0000);
		end
		$display("interrupt test done");
		chk(pp_oe, 16'h0000);
		op(6, 16'ha5c3, 4'h0);
		chk(pp_out, 16'ha5c3);
		chk(pp_oe, 16'h0001);
		op(5, 16'h0005, 4'h0);
		chk({open_drain_out_pin, open_drain_oe}, 16'h000a);
		op(7, 16'h000d, 4'h0);
		chk(tone_freq_sel, 16'h0005);
		for (int w = 0; w < 2; w++)
		begin
			@(negedge clk) tone_wave = w[0];
			#1 chk(tone_shared_out_pin, w[0]);
		end
		$display("output test done");
		op(8, 16'h0000, 4'h0);
		chk(halted, 16'h0000);
		{suspend_enable_flag, suspend_req, phase_cmd} = 4'b1101;
		cyc(3);
		chk({fm_to_pll, main_pump_oe, second_pump_oe, aux_pump_oe}, 16'h0000);
		op(8, 16'h0000, 4'h0);
		chk(halted, 16'h0001);
		chk({count_pins_pulldown, pp_oe, open_drain_oe}, 16'h0020);
		suspend_req = 1'b0;
		n = 0;
		while (halted !== 1'b0 && n < 10)
		begin
			@(negedge clk);
			n++;
		end
		chk({halted, n < 5}, 16'h0001);
		$display("halt test done");
		arst_n = 1'b0;
		cyc(2);
		chk({pp_oe, tone_shared_oe, open_drain_oe, counter_mode}, 16'h0000);
		arst_n = 1'b1;
		cyc(2);
		$display("second reset test done");
		test_done;
	end
endmodule : test_tuner_mcu_pin_function_control
